// File: design/pdsr_pkg.sv
// package for the power-down / stop-recovery controller
// assumes an 8-bit expanded register file port in bank f
package pdsr_pkg;
  localparam logic [3:0] PDSR_BANK_F = 4'hf;
  localparam logic [7:0] PDSR_STOP_RECOVERY_CONTROL_OFS = 8'h0b;
  localparam int PDSR_DIV16_BIT = 0;
  localparam int PDSR_NODIV2_BIT = 1;
  localparam int PDSR_SRC_LO = 2;
  localparam int PDSR_DELAY_BIT = 5;
  localparam int PDSR_LEVEL_BIT = 6;
  localparam int PDSR_WARM_BIT = 7;
  localparam logic [6:0] PDSR_CTRL_RESET = 7'h20;
  localparam logic [7:0] PDSR_OP_NOP = 8'hff;
  localparam logic [7:0] PDSR_OP_HALT = 8'h7f;
  localparam logic [7:0] PDSR_OP_STOP = 8'h6f;
  localparam logic [15:0] PDSR_RESTART_ADDR = 16'h000c;
  localparam int PDSR_CLK_MHZ = 200;
  localparam int PDSR_FAST_WAKE_PERIODS = 5;
  localparam int PDSR_POR_DELAY_NS = 1000;
  localparam int PDSR_POR_DELAY_CYC = PDSR_POR_DELAY_NS * PDSR_CLK_MHZ / 1000;
  localparam int PDSR_WDT_STOP_CYC = 1024;

  typedef enum logic [1:0] {
    PDSR_RUN = 2'b00,
    PDSR_HALT = 2'b01,
    PDSR_STOP = 2'b10,
    PDSR_WAKE = 2'b11
  } pdsr_mode_t;

  typedef struct packed {
    logic [3:0] bank;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pdsr_reg_req_t;

  typedef struct packed {
    logic [7:0] port2;
    logic [3:0] port3;
  } pdsr_wake_pins_t;
endpackage

// File: design/pdsr_power_down.sv
// power-down controller: run, halt, stop and recovery
// assumes the core flags each fetched opcode and honours cpu_clk_en
`timescale 1ns/1ps
module pdsr_power_down import pdsr_pkg::*; #(
  parameter int POR_DELAY_CYC = PDSR_POR_DELAY_CYC,
  parameter int WDT_STOP_CYC = PDSR_WDT_STOP_CYC,
  parameter int FAST_WAKE_CYC = PDSR_FAST_WAKE_PERIODS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic por,
  input wire logic reset_pin,
  input wire logic wdt_timeout,
  input wire logic wdt_stop_enable,
  input wire logic irq_pending,
  input wire logic opcode_valid,
  input wire logic [7:0] opcode,
  input wire pdsr_reg_req_t reg_req,
  input wire pdsr_wake_pins_t wake_pins,
  output logic [7:0] reg_rdata,
  output logic cpu_clk_en,
  output logic timer_clk_en,
  output logic osc_enable,
  output logic core_reset,
  output logic [15:0] restart_addr,
  output logic recovery_reset,
  output pdsr_mode_t mode
);

  // a zero count would wrap the limit to all ones, so the wake or stop timer would not end
  if (POR_DELAY_CYC < 1) begin : g_bad_por
    $error("pdsr: POR_DELAY_CYC must be at least one");
  end
  if (WDT_STOP_CYC < 1) begin : g_bad_wdt
    $error("pdsr: WDT_STOP_CYC must be at least one");
  end
  if (FAST_WAKE_CYC < 1) begin : g_bad_fast
    $error("pdsr: FAST_WAKE_CYC must be at least one");
  end


  logic [6:0] ctrl_reg;
  logic warm_reg;
  pdsr_mode_t mode_reg;
  logic prev_nop_reg;
  logic [31:0] cnt_reg;
  logic [3:0] presc_reg;
  logic div2_reg;
  logic recov_reset_reg;
  logic core_reset_reg;
  logic [15:0] restart_reg;
  logic wake_latch;
  logic wake_raw;
  logic hard_reset;
  logic reg_hit;
  logic reg_write;
  logic wake_armed;
  logic halt_entry;
  logic stop_entry;
  logic stop_wdt_expire;
  logic stop_exit;
  logic wake_done;
  logic halt_wdt_reset;
  logic stop_hold_reset;
  logic base_tick;
  logic clk_tick;
  logic [7:0] port2_low;

  // per-pin low detect feeding the two nor sources
  for (genvar i = 0; i < 8; i++) begin : g_port2_low
    assign port2_low[i] = ~wake_pins.port2[i];
  end


  function automatic logic wake_select(input logic [2:0] sel,
                                       input pdsr_wake_pins_t p,
                                       input logic [7:0] low);
    case (sel)
      3'b000: wake_select = 1'b0;
      3'b001: wake_select = p.port3[0];
      3'b010: wake_select = p.port3[1];
      3'b011: wake_select = p.port3[2];
      3'b100: wake_select = p.port3[3];
      3'b101: wake_select = p.port2[7];
      3'b110: wake_select = &low[3:0];
      3'b111: wake_select = &low;
      default: wake_select = 1'b0;
    endcase
  endfunction

  // an entry opcode counts only straight after a nop
  function automatic logic entry_decode(input logic valid,
                                        input logic after_nop,
                                        input logic [7:0] op,
                                        input logic [7:0] code);
    entry_decode = valid && after_nop && op == code;
  endfunction

  assign hard_reset = rst | por | reset_pin;
  assign reg_hit = reg_req.bank == PDSR_BANK_F &&
                   reg_req.addr == PDSR_STOP_RECOVERY_CONTROL_OFS;
  assign reg_write = reg_req.wr && reg_hit;
  assign halt_entry = entry_decode(opcode_valid, prev_nop_reg, opcode,
                                   PDSR_OP_HALT);
  assign stop_entry = entry_decode(opcode_valid, prev_nop_reg, opcode,
                                   PDSR_OP_STOP);

  // source select; code 000 never wakes
  // level select: xor turns active level into a high
  assign wake_armed = ctrl_reg[4:PDSR_SRC_LO] != 3'b000;
  assign wake_raw = wake_select(ctrl_reg[4:PDSR_SRC_LO], wake_pins,
                                port2_low) ^ ~ctrl_reg[PDSR_LEVEL_BIT];

  // clockless wake latch
  // no clock runs in stop without wdt_stop_enable, so the source is caught asynchronously
  always_latch begin
    if (hard_reset || mode_reg != PDSR_STOP) begin
      wake_latch = 1'b0;
    end else if (wake_raw && wake_armed) begin
      wake_latch = 1'b1;
    end
  end

  // the internal stop timer only runs with the watchdog
  assign stop_wdt_expire = (wdt_stop_enable &&
                            cnt_reg >= 32'(WDT_STOP_CYC - 1)) ||
                           wdt_timeout;
  // stop ends only by watchdog or recovery source
  assign stop_exit = stop_wdt_expire || wake_latch;
  // fast wake still waits the source hold time
  assign wake_done = ctrl_reg[PDSR_DELAY_BIT] ?
                     cnt_reg >= 32'(POR_DELAY_CYC - 1) :
                     cnt_reg >= 32'(FAST_WAKE_CYC - 1);


  // divide bits take effect at once
  always_ff @(posedge sys_clk) begin
    if (rst || por) begin
      ctrl_reg <= PDSR_CTRL_RESET;
    end else if (clk_en) begin
      if (recov_reset_reg) begin
        ctrl_reg <= ctrl_reg;
      end else if (reg_write) begin
        ctrl_reg <= reg_req.wdata[6:0];
      end
    end
  end


  // only the warm flag reads back
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_req.rd && reg_hit) begin
      reg_rdata[PDSR_WARM_BIT] = warm_reg;
    end
  end

  // warm flag; a wake in the same cycle as a timeout wins
  always_ff @(posedge sys_clk) begin
    if (rst || por) begin
      warm_reg <= 1'b0;
    end else if (clk_en) begin
      if (mode_reg == PDSR_STOP && wake_latch) begin
        warm_reg <= 1'b1;
      end else if (mode_reg == PDSR_STOP && stop_wdt_expire) begin
        warm_reg <= 1'b0;
      end
    end
  end

  // nop tracking; entry is honoured only after a nop
  always_ff @(posedge sys_clk) begin
    if (hard_reset) begin
      prev_nop_reg <= 1'b0;
    end else if (clk_en && opcode_valid) begin
      prev_nop_reg <= opcode == PDSR_OP_NOP;
    end
  end


  always_ff @(posedge sys_clk) begin
    if (hard_reset) begin
      mode_reg <= PDSR_RUN;
      cnt_reg <= 32'h0;
      recov_reset_reg <= 1'b0;
    end else if (clk_en) begin
      case (mode_reg)
        PDSR_RUN: begin
          recov_reset_reg <= 1'b0;
          cnt_reg <= 32'h0;
          if (halt_entry) begin
            mode_reg <= PDSR_HALT;
          end else if (stop_entry) begin
            mode_reg <= PDSR_STOP;
          end
        end
        PDSR_HALT: begin
          if (wdt_timeout)
            mode_reg <= PDSR_RUN;
          else if (irq_pending)
            mode_reg <= PDSR_RUN;
        end
        PDSR_STOP: begin
          cnt_reg <= cnt_reg + 32'h1;
          // port2 bit7 at the selected level when selected
          if (stop_exit) begin
            mode_reg <= PDSR_WAKE;
            cnt_reg <= 32'h0;
            recov_reset_reg <= 1'b1;
          end
        end
        PDSR_WAKE: begin
          cnt_reg <= cnt_reg + 32'h1;
          if (wake_done) begin
            mode_reg <= PDSR_RUN;
            cnt_reg <= 32'h0;
          end
        end
        default: begin
          mode_reg <= PDSR_RUN;
        end
      endcase
    end
  end

  assign halt_wdt_reset = mode_reg == PDSR_HALT && wdt_timeout;
  assign stop_hold_reset = mode_reg == PDSR_STOP ||
                           mode_reg == PDSR_WAKE;


  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_reset_reg <= 1'b1;
      restart_reg <= PDSR_RESTART_ADDR;
    end else if (clk_en) begin
      restart_reg <= PDSR_RESTART_ADDR;
      core_reset_reg <= por | reset_pin | halt_wdt_reset |
                        stop_hold_reset;
    end
  end


  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div2_reg <= 1'b0;
      presc_reg <= 4'h0;
    end else if (clk_en) begin
      div2_reg <= ~div2_reg;
      if (base_tick) begin
        presc_reg <= presc_reg + 4'h1;
      end
    end
  end

  // the prescaler only moves on base ticks, so div16 stacks on div2
  assign base_tick = ctrl_reg[PDSR_NODIV2_BIT] | div2_reg;
  assign clk_tick = base_tick &
                    (~ctrl_reg[PDSR_DIV16_BIT] | presc_reg == 4'hf);


  // cpu gated in halt, timer clock kept
  assign cpu_clk_en = clk_tick & (mode_reg == PDSR_RUN);
  assign timer_clk_en = clk_tick &
                        (mode_reg == PDSR_RUN || mode_reg == PDSR_HALT);
  assign osc_enable = mode_reg != PDSR_STOP || wdt_stop_enable;
  assign core_reset = core_reset_reg;
  assign restart_addr = restart_reg;
  // tells other blocks to load recovery values
  assign recovery_reset = recov_reset_reg;
  assign mode = mode_reg;
endmodule

// File: dv/pdsr_checker.sv
// checker for the power-down controller ports
// assumes one sys_clk domain with sync active-high rst
`timescale 1ns/1ps
module pdsr_checker import pdsr_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic irq_pending,
  input wire logic wdt_stop_enable,
  input wire logic [7:0] reg_rdata,
  input wire logic cpu_clk_en,
  input wire logic osc_enable,
  input wire logic core_reset,
  input wire logic [15:0] restart_addr,
  input wire logic recovery_reset,
  input wire pdsr_mode_t mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_halt;
    mode == PDSR_HALT |-> !cpu_clk_en && osc_enable;
  endproperty
  a_halt: assert property (p_halt) else $error("halt gating");
  property p_irq;
    mode == PDSR_HALT && irq_pending && clk_en |=> mode == PDSR_RUN;
  endproperty
  a_irq: assert property (p_irq) else $error("irq exit");
  property p_restart;
    core_reset |-> restart_addr == PDSR_RESTART_ADDR;
  endproperty
  a_restart: assert property (p_restart) else $error("restart");
  property p_stop;
    mode == PDSR_STOP && !wdt_stop_enable |-> !osc_enable && !cpu_clk_en;
  endproperty
  a_stop: assert property (p_stop) else $error("stop clocks");
  property p_exit;
    $rose(recovery_reset) |-> mode == PDSR_WAKE;
  endproperty
  a_exit: assert property (p_exit) else $error("stop exit");
  property p_rec;
    mode == PDSR_WAKE |-> recovery_reset;
  endproperty
  a_rec: assert property (p_rec) else $error("recovery reset");
  property p_wo;
    reg_rdata[6:0] == 7'h00;
  endproperty
  a_wo: assert property (p_wo) else $error("write-only bits");
  property p_end;
    $fell(mode == PDSR_WAKE) |-> mode == PDSR_RUN ##1 !core_reset;
  endproperty
  a_end: assert property (p_end) else $error("wake end");
  c_halt: cover property (mode == PDSR_HALT);
  c_stop: cover property (mode == PDSR_STOP);
  c_wake: cover property (mode == PDSR_WAKE);
endmodule
bind pdsr_power_down pdsr_checker pdsr_checker_inst (.sys_clk(sys_clk),
  .rst(rst), .clk_en(clk_en), .irq_pending(irq_pending),
  .wdt_stop_enable(wdt_stop_enable), .reg_rdata(reg_rdata),
  .cpu_clk_en(cpu_clk_en), .osc_enable(osc_enable),
  .core_reset(core_reset), .restart_addr(restart_addr),
  .recovery_reset(recovery_reset), .mode(mode));

// File: dv/pdsr_wake_src.sv
// wake pin model: port2 and port3 inputs
// assumes the bench holds act for at least five cycles
`timescale 1ns/1ps
module pdsr_wake_src import pdsr_pkg::*; (
  input wire logic [3:0] sel,
  input wire logic act,
  input wire logic lvl,
  output pdsr_wake_pins_t pins
);
  logic [11:0] v;
  always_comb begin
    v = {12{~lvl}};
    if (act) v[sel] = lvl;
  end
  assign pins = v;
endmodule

// File: dv/test_power_down_stop_recovery.sv
// bench: halt, stop, wake paths and register reads
// assumes the wake pin model on the far side
`timescale 1ns/1ps
module test_power_down_stop_recovery;
  import pdsr_pkg::*;
  logic sys_clk = 0, rst = 1, clk_en = 1, por = 0, reset_pin = 0;
  logic wdt_timeout = 0, wdt_en = 0, irq = 0, opv = 0, act = 0, lvl = 1;
  logic [7:0] opc = 8'h00, rdata;
  logic [3:0] sel = 4'h0;
  logic cpu_en, tmr_en, osc_en, core_reset, rec_rst;
  logic [15:0] raddr;
  pdsr_reg_req_t req = '0;
  pdsr_wake_pins_t pins;
  pdsr_mode_t mode;
  int fail_count = 0, num_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  pdsr_power_down #(.POR_DELAY_CYC(4), .WDT_STOP_CYC(8))
    pdsr_power_down_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .por(por), .reset_pin(reset_pin), .wdt_timeout(wdt_timeout),
    .wdt_stop_enable(wdt_en), .irq_pending(irq), .opcode_valid(opv),
    .opcode(opc), .reg_req(req), .wake_pins(pins), .reg_rdata(rdata),
    .cpu_clk_en(cpu_en), .timer_clk_en(tmr_en), .osc_enable(osc_en),
    .core_reset(core_reset), .restart_addr(raddr),
    .recovery_reset(rec_rst), .mode(mode));
  pdsr_wake_src pdsr_wake_src_inst (.sel(sel), .act(act), .lvl(lvl),
    .pins(pins));
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmp(input string s, input logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic op2(input logic [7:0] a, input logic [7:0] b);
    opv = 1;
    opc = a;
    tick(1);
    opc = b;
    tick(1);
    opv = 0;
    tick(1);
  endtask
  task automatic wait_mode(input pdsr_mode_t m, output int n);
    n = 0;
    while (mode !== m && n < 40) begin
      tick(1);
      n++;
    end
    cmp("mode", 16'(m), 16'(mode));
  endtask
  task automatic reg_io(input logic wr, input logic [7:0] v);
    req = {PDSR_BANK_F, PDSR_STOP_RECOVERY_CONTROL_OFS, v, wr, ~wr};
    #1;
    if (!wr) cmp("rdata", {8'h00, v}, {8'h00, rdata});
    tick(1);
    req = '0;
  endtask
  task automatic t_halt;
    int n;
    op2(PDSR_OP_NOP, PDSR_OP_HALT);
    cmp("halt", 16'(PDSR_HALT), 16'(mode));
    cmp("cpu_en", 16'h0, 16'(cpu_en));
    n = 0;
    repeat (2) begin
      n += int'(tmr_en);
      tick(1);
    end
    cmp("tmr_en", 16'h1, 16'(n));
    clk_en = 0;
    irq = 1;
    tick(3);
    cmp("freeze", 16'(PDSR_HALT), 16'(mode));
    clk_en = 1;
    wait_mode(PDSR_RUN, n);
    irq = 0;
    op2(8'h00, PDSR_OP_HALT);
    cmp("no_nop", 16'(PDSR_RUN), 16'(mode));
    op2(PDSR_OP_NOP, PDSR_OP_HALT);
    wdt_timeout = 1;
    tick(1);
    wdt_timeout = 0;
    cmp("wdt_halt", 16'(PDSR_RUN), 16'(mode));
    cmp("core_reset", 16'h1, 16'(core_reset));
    tick(1);
    op2(PDSR_OP_NOP, PDSR_OP_HALT);
    reset_pin = 1;
    tick(1);
    reset_pin = 0;
    wait_mode(PDSR_RUN, n);
    cmp("restart", 16'h000c, raddr);
    $display("test halt done");
  endtask
  task automatic t_stop(input logic [2:0] src, input logic l, dly,
                        input int pin, ncyc, input logic warm);
    int n;
    reg_io(1, {1'b0, l, dly, src, 2'b00});
    lvl = l;
    sel = pin[3:0];
    wdt_en = (pin < 0);
    op2(PDSR_OP_NOP, PDSR_OP_STOP);
    cmp("stop", 16'(PDSR_STOP), 16'(mode));
    cmp("osc", 16'(pin < 0), 16'(osc_en));
    act = (pin >= 0);
    wait_mode(PDSR_WAKE, n);
    cmp("rec_rst", 16'h1, 16'(rec_rst));
    wait_mode(PDSR_RUN, n);
    cmp("delay", 16'(ncyc), 16'(n));
    act = 0;
    wdt_en = 0;
    tick(2);
    reg_io(0, {warm, 7'h00});
    $display("test stop done");
  endtask
  task automatic count_cpu(input int w, input int e);
    int c;
    c = 0;
    repeat (w) begin
      c += int'(cpu_en);
      tick(1);
    end
    cmp("cpu_en_rate", 16'(e), 16'(c));
  endtask
  task automatic t_clk;
    reg_io(1, 8'h21);
    count_cpu(32, 1);
    reg_io(1, 8'h23);
    count_cpu(16, 1);
    reg_io(1, 8'h22);
    count_cpu(8, 8);
    reg_io(1, 8'h20);
    count_cpu(8, 4);
    $display("test clock divide done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    tick(8);
    rst = 0;
    tick(2);
    reg_io(0, 8'h00);
    t_halt();
    t_clk();
    t_stop(3'b101, 0, 1, 11, 4, 1);
    por = 1;
    tick(1);
    por = 0;
    tick(1);
    reg_io(0, 8'h00);
    t_stop(3'b001, 1, 0, 0, 5, 1);
    t_stop(3'b000, 0, 1, -1, 4, 0);
    end_sim();
  end
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end
endmodule
